// ### rtl/dfgm_modulator.sv
`default_nettype none
module dfgm_modulator (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [dfgm_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [dfgm_pkg::DATA_W-1:0]   pwdata,
  output logic      [dfgm_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [7:0]                    frac_low_byte,
  output dfgm_pkg::dfgm_synth_t              synth,
  output logic                               ask_level,
  output logic                               tx_busy
);
  localparam logic [4:0] POS_TOP = 5'(dfgm_pkg::STEPS_PER_CHIP);

  // register file
  logic [7:0] tx_cfg;
  logic [7:0] frac_mid  [4];
  logic [7:0] frac_high [4];
  logic [7:0] dev_cfg;
  logic [7:0] step_div;
  logic [7:0] shape_cfg;
  logic [7:0] ctrl;

  // bus decode
  logic [7:0]  acc_idx;
  logic        acc_aligned;
  logic        wr_done;
  logic        is_data_wr;
  logic        mapped;
  logic [31:0] next_prdata;
  logic        hit_mid;
  logic        hit_high;

  // datapath
  logic [7:0]  fifo_out;
  logic        fifo_valid;
  logic        fifo_in_ready;
  logic        fifo_pop;
  logic [7:0]  step_cnt;
  logic        step_tick;
  logic [3:0]  phase;
  logic [7:0]  chip_sh;
  logic [3:0]  chips_left;
  logic        chip_raw;
  logic        active;
  logic [4:0]  shape_pos;
  logic        level;
  logic        is_fsk;
  logic        shaping_on;
  logic [1:0]  chan;
  logic [19:0] dev_lsb;
  logic [20:0] centre;
  logic [20:0] next_frac;
  dfgm_pkg::dfgm_status_t status;

  function automatic logic [1:0] chan_of(input logic [7:0] idx, input logic [7:0] base);
    chan_of = 2'((idx - base) >> 2);
  endfunction

  function automatic logic is_chan_reg(input logic [7:0] idx, input logic [7:0] base);
    is_chan_reg = (idx >= base) && (idx <= 8'(base + 8'h0C)) && (idx[1:0] == base[1:0]);
  endfunction

  // cumulative Gaussian weight in 1/256 of full swing, symmetric about 128
  // table kept short: 16 steps each way, end points exact
  function automatic logic [8:0] gauss_w(input logic [4:0] p);
    case (p)
      5'h00: gauss_w = 9'h000;
      5'h01: gauss_w = 9'h003;
      5'h02: gauss_w = 9'h008;
      5'h03: gauss_w = 9'h010;
      5'h04: gauss_w = 9'h01D;
      5'h05: gauss_w = 9'h02E;
      5'h06: gauss_w = 9'h044;
      5'h07: gauss_w = 9'h060;
      5'h08: gauss_w = 9'h080;
      5'h09: gauss_w = 9'h0A0;
      5'h0A: gauss_w = 9'h0BC;
      5'h0B: gauss_w = 9'h0D2;
      5'h0C: gauss_w = 9'h0E3;
      5'h0D: gauss_w = 9'h0F0;
      5'h0E: gauss_w = 9'h0F8;
      5'h0F: gauss_w = 9'h0FD;
      default: gauss_w = 9'h100;
    endcase
  endfunction

  assign acc_idx     = paddr[9:2];
  assign acc_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign is_data_wr  = pwrite && (acc_idx == dfgm_pkg::IDX_TX_DATA);
  assign wr_done     = psel && penable && pready && pwrite && !pslverr;
  // channel windows shared by the read and write paths
  assign hit_mid     = is_chan_reg(acc_idx, dfgm_pkg::IDX_MID_A);
  assign hit_high    = is_chan_reg(acc_idx, dfgm_pkg::IDX_HIGH_A);

  always_comb begin
    mapped = acc_aligned;
    next_prdata = '0;
    if (hit_mid) begin
      next_prdata[7:0] = frac_mid[chan_of(acc_idx, dfgm_pkg::IDX_MID_A)];
    end else if (hit_high) begin
      // unused top bits read as zero
      next_prdata[5:0] = frac_high[chan_of(acc_idx, dfgm_pkg::IDX_HIGH_A)][5:0];
    end else begin
      case (acc_idx)
        dfgm_pkg::IDX_TX_CFG:    next_prdata[7:0] = tx_cfg;
        dfgm_pkg::IDX_DEV:       next_prdata[7:0] = dev_cfg;
        dfgm_pkg::IDX_STEP_DIV:  next_prdata[7:0] = step_div;
        dfgm_pkg::IDX_SHAPE_CFG: next_prdata[7:0] = shape_cfg;
        dfgm_pkg::IDX_CTRL:      next_prdata[7:0] = ctrl;
        dfgm_pkg::IDX_TX_DATA:   next_prdata = '0;
        dfgm_pkg::IDX_STATUS:    next_prdata[$bits(status)-1:0] = status;
        default:                 mapped = 1'b0;
      endcase
    end
  end

  // one wait state; a data write also waits while the FIFO is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && penable && !pready) begin
      if (!(is_data_wr && mapped && !fifo_in_ready)) begin
        pready  <= 1'b1;
        pslverr <= !mapped;
        // refused reads return zero so nothing of a register leaks out
        prdata  <= (pwrite || !mapped) ? '0 : next_prdata;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cfg    <= dfgm_pkg::RST_TX_CFG;
      dev_cfg   <= dfgm_pkg::RST_DEV;
      step_div  <= dfgm_pkg::RST_STEP_DIV;
      shape_cfg <= dfgm_pkg::RST_SHAPE_CFG;
    end else if (wr_done) begin
      case (acc_idx)
        dfgm_pkg::IDX_TX_CFG:    tx_cfg <= pwdata[7:0];
        dfgm_pkg::IDX_DEV:       dev_cfg <= pwdata[7:0];
        dfgm_pkg::IDX_STEP_DIV:  step_div <= pwdata[7:0];
        dfgm_pkg::IDX_SHAPE_CFG: shape_cfg <= pwdata[7:0];
        default:                 ;
      endcase
    end
  end

  // command bits: tx enable, setup select, channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= dfgm_pkg::RST_CTRL;
    end else if (wr_done && acc_idx == dfgm_pkg::IDX_CTRL) begin
      ctrl <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        frac_mid[i]  <= dfgm_pkg::RST_MID;
        frac_high[i] <= dfgm_pkg::RST_HIGH;
      end
    end else if (wr_done) begin
      if (hit_mid) begin
        frac_mid[chan_of(acc_idx, dfgm_pkg::IDX_MID_A)] <= pwdata[7:0];
      end
      if (hit_high) begin
        // reserved bit 5 kept as written, top two not stored
        frac_high[chan_of(acc_idx, dfgm_pkg::IDX_HIGH_A)] <=
          {2'h0, pwdata[dfgm_pkg::HIGH_KEEP_W-1:0]};
      end
    end
  end

  dfgm_fifo #(
    .WIDTH (8),
    .DEPTH (dfgm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_data   (pwdata[7:0]),
    .in_valid  (wr_done && is_data_wr),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // command bit picks the active setup, each setup says ASK or FSK
  assign is_fsk = ctrl[dfgm_pkg::BIT_SETUP_SEL] ? tx_cfg[dfgm_pkg::BIT_SETUP2_FSK]
                                                : tx_cfg[dfgm_pkg::BIT_SETUP1_FSK];
  assign shaping_on = is_fsk && !shape_cfg[dfgm_pkg::BIT_BYPASS];
  // channel switch takes effect at once, even mid-word
  assign chan = ctrl[dfgm_pkg::LSB_CHAN +: 2];
  assign centre = {frac_high[chan][4:0], frac_mid[chan], frac_low_byte};

  // deviation in fractional LSBs, scale 2^code/64, rounded
  assign dev_lsb = 20'((28'(dfgm_pkg::DEV_MULT) * 28'(dev_cfg[4:0])
                    * (28'(1) << dev_cfg[dfgm_pkg::LSB_SCALE +: 3])
                    + 28'(1 << (dfgm_pkg::DEV_SHIFT - 1))) >> dfgm_pkg::DEV_SHIFT);

  // one tick every step_div + 1 clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt  <= '0;
      step_tick <= 1'b0;
    end else if (step_cnt >= step_div) begin
      step_cnt  <= '0;
      step_tick <= 1'b1;
    end else begin
      step_cnt  <= 8'(step_cnt + 1'b1);
      step_tick <= 1'b0;
    end
  end

  // a chip lasts 16 ticks so that the steps span one chip when divided right
  assign fifo_pop = step_tick && (phase == 4'hF) && (chips_left == 4'h0)
                    && ctrl[dfgm_pkg::BIT_TX_EN];

  // free-running tick count within a chip; chip edges fall on its wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
    end else if (step_tick) begin
      phase <= 4'(phase + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_sh    <= '0;
      chips_left <= '0;
      chip_raw   <= 1'b0;
      active     <= 1'b0;
    end else if (step_tick) begin
      if (phase == 4'hF) begin
        if (chips_left != 4'h0) begin
          chip_raw   <= chip_sh[0];
          chip_sh    <= chip_sh >> 1;
          chips_left <= 4'(chips_left - 1'b1);
          active     <= 1'b1;
        end else if (fifo_pop && fifo_valid) begin
          // word sent lsb chip first
          chip_raw   <= fifo_out[0];
          chip_sh    <= fifo_out >> 1;
          chips_left <= 4'(dfgm_pkg::CHIPS_PER_WORD - 1);
          active     <= 1'b1;
        end else begin
          active <= 1'b0;
        end
      end
    end
  end

  // idle keeps the last level, so the carrier rests on that side
  assign level = chip_raw ^ tx_cfg[dfgm_pkg::BIT_INVERT];

  // position 0 is full negative, 16 full positive deviation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shape_pos <= '0;
    end else if (!shaping_on) begin
      shape_pos <= level ? POS_TOP : 5'h00;
    end else if (step_tick) begin
      // one step per tick, holds at target
      // a reversal mid-transition walks back from where it stands
      if (level && shape_pos < POS_TOP) begin
        shape_pos <= 5'(shape_pos + 1'b1);
      end else if (!level && shape_pos != 5'h00) begin
        shape_pos <= 5'(shape_pos - 1'b1);
      end
    end
  end

  // centre minus dev plus a weighted share of twice dev
  always_comb begin
    logic [29:0] span;
    span = 30'({dev_lsb, 1'b0}) * 30'(gauss_w(shape_pos));
    next_frac = 21'(centre - 21'(dev_lsb) + 21'(span >> 8));
  end

  // registered so the divider sees one settled value per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth <= '0;
    end else if (is_fsk) begin
      synth.frac     <= next_frac;
      synth.fsk_high <= level;
    end else begin
      // ASK keeps the carrier at centre; level goes to the PA
      synth.frac     <= centre;
      synth.fsk_high <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ask_level <= 1'b0;
    end else begin
      // only keyed while a chip is on air, so idle ASK stays off
      ask_level <= !is_fsk && level && active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy <= 1'b0;
    end else begin
      tx_busy <= active || fifo_valid;
    end
  end

  assign status.shape_pos  = shape_pos;
  assign status.busy       = active;
  assign status.level      = level;
  assign status.fifo_full  = !fifo_in_ready;
  assign status.fifo_empty = !fifo_valid;
endmodule // dfgm_modulator
`default_nettype wire

// ### rtl/dfgm_pkg.sv
`default_nettype none
package dfgm_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TX_CFG = 8'h05;
  localparam logic [7:0] IDX_MID_A = 8'h0B;
  localparam logic [7:0] IDX_MID_B = 8'h0F;
  localparam logic [7:0] IDX_MID_C = 8'h13;
  localparam logic [7:0] IDX_MID_D = 8'h17;
  localparam logic [7:0] IDX_HIGH_A = 8'h0C;
  localparam logic [7:0] IDX_HIGH_B = 8'h10;
  localparam logic [7:0] IDX_HIGH_C = 8'h14;
  localparam logic [7:0] IDX_HIGH_D = 8'h18;
  localparam logic [7:0] IDX_DEV = 8'h1C;
  localparam logic [7:0] IDX_STEP_DIV = 8'h1D;
  localparam logic [7:0] IDX_SHAPE_CFG = 8'h1E;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_TX_DATA = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  // reset values
  localparam logic [7:0] RST_TX_CFG = 8'h03;
  localparam logic [7:0] RST_MID = 8'h00;
  localparam logic [7:0] RST_HIGH = 8'h10;
  localparam logic [7:0] RST_DEV = 8'hDF;
  localparam logic [7:0] RST_STEP_DIV = 8'h08;
  localparam logic [7:0] RST_SHAPE_CFG = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // field positions and widths
  localparam int unsigned BIT_INVERT = 3;
  localparam int unsigned BIT_SETUP1_FSK = 0;
  localparam int unsigned BIT_SETUP2_FSK = 1;
  localparam int unsigned BIT_BYPASS = 3;
  localparam int unsigned BIT_TX_EN = 0;
  localparam int unsigned BIT_SETUP_SEL = 1;
  localparam int unsigned LSB_CHAN = 2;
  localparam int unsigned LSB_SCALE = 5;
  localparam int unsigned HIGH_KEEP_W = 6;
  localparam int unsigned FRAC_W = 21;
  // shaping, deviation, FIFO depth and word length figures
  localparam int unsigned STEPS_PER_CHIP = 16;
  localparam int unsigned DEV_MULT = 190;
  localparam int unsigned DEV_SHIFT = 6;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CHIPS_PER_WORD = 8;

  typedef struct packed {
    logic [FRAC_W-1:0] frac;
    logic              fsk_high;
  } dfgm_synth_t;

  typedef struct packed {
    logic [4:0] shape_pos;
    logic       busy;
    logic       level;
    logic       fifo_full;
    logic       fifo_empty;
  } dfgm_status_t;
endpackage
`default_nettype wire

// ### rtl/dfgm_fifo.sv
`default_nettype none
module dfgm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= (PW+1)'(count + push - pop);
    end
  end
endmodule // dfgm_fifo
`default_nettype wire

// ### dv/dfgm_properties.sv
`default_nettype none
module dfgm_properties (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic [dfgm_pkg::ADDR_W-1:0] paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [dfgm_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  a_upper_zero: assert property (pready |-> prdata[31:9] == 23'h0
      && (prdata[8] == 1'b0 || paddr[9:2] == dfgm_pkg::IDX_STATUS))
    else $error("upper read bits set");
  a_high_top_zero: assert property (pready && !pwrite && paddr[9:2] == dfgm_pkg::IDX_HIGH_C |-> prdata[7:6] == 2'h0)
    else $error("unused high bits read set");
  a_misaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned not refused");
  a_mapped_ok: assert property (pready && paddr == 12'h02C |-> !pslverr)
    else $error("mapped access refused");
  a_access_wait: assert property (psel && !penable ##1 psel && penable
      && !(pwrite && paddr[9:2] == dfgm_pkg::IDX_TX_DATA) |-> !pready ##1 pready)
    else $error("access latency wrong");
endmodule // dfgm_properties
bind dfgm_modulator dfgm_properties dfgm_properties_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### dv/dfgm_synth_model.sv
`default_nettype none
module dfgm_synth_model #(
  parameter logic [7:0] LOW = 8'h45
) (
  input wire logic                  pclk,
  input wire logic                  clear,
  input wire dfgm_pkg::dfgm_synth_t synth,
  output logic [7:0]                frac_low_byte,
  output logic [15:0]               changes,
  output logic [15:0]               span
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [20:0] last_frac;
  logic [15:0] since;
  assign frac_low_byte = LOW;
  // divider only ever sees whole fraction values; count its switches
  always @(posedge pclk) begin
    last_frac <= synth.frac;
    if (clear) begin
      changes <= 16'h0;
      span <= 16'h0;
      since <= 16'h0;
    end else begin
      if (changes != 16'h0) since <= since + 16'h1;
      if (synth.frac != last_frac) begin
        changes <= changes + 16'h1;
        if (changes != 16'h0) span <= since + 16'h1;
      end
    end
  end
endmodule // dfgm_synth_model
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [20:0] CA = 21'h012345;
  localparam logic [20:0] CB = 21'h027745;
  localparam logic [20:0] DEV = 21'((190 * 1 * 64 + 32) / 64);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ask_level, tx_busy, clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] frac_low_byte;
  logic [15:0] changes, span;
  logic err;
  dfgm_pkg::dfgm_synth_t synth;
  int errors, compares;
  dfgm_modulator dfgm_modulator_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frac_low_byte(frac_low_byte), .synth(synth), .ask_level(ask_level), .tx_busy(tx_busy));
  dfgm_synth_model dfgm_synth_model_inst (.pclk(pclk), .clear(clear), .synth(synth),
    .frac_low_byte(frac_low_byte), .changes(changes), .span(span));
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 5000);
    if (n >= 5000) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    apb(1'h1, {2'h0, idx, 2'h0}, d);
  endtask
  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'h0, {2'h0, idx, 2'h0}, 8'h0);
    check("register", rd, {24'h0, exp});
    check("register error", {31'h0, err}, 32'h0);
  endtask
  // waits for the word to drain, bounded by the watchdog-free local limit
  task automatic drain;
    int n;
    n = 0;
    repeat (3) @(posedge pclk);
    while (tx_busy !== 1'h0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) errors++;
    repeat (3) @(posedge pclk);
  endtask
  task automatic send(input logic [7:0] d);
    wreg(dfgm_pkg::IDX_TX_DATA, d);
    drain();
  endtask
  task automatic test_regs;
    logic [7:0] mids [4];
    mids = '{dfgm_pkg::IDX_MID_A, dfgm_pkg::IDX_MID_B, dfgm_pkg::IDX_MID_C, dfgm_pkg::IDX_MID_D};
    rreg(dfgm_pkg::IDX_TX_CFG, 8'h03);
    rreg(dfgm_pkg::IDX_HIGH_A, 8'h10);
    rreg(dfgm_pkg::IDX_DEV, 8'hDF);
    rreg(dfgm_pkg::IDX_STEP_DIV, 8'h08);
    foreach (mids[i]) rreg(mids[i], 8'h00);
    foreach (mids[i]) wreg(mids[i], 8'h11 * 8'(i + 1));
    foreach (mids[i]) rreg(mids[i], 8'h11 * 8'(i + 1));
    wreg(dfgm_pkg::IDX_HIGH_C, 8'hDF);
    rreg(dfgm_pkg::IDX_HIGH_C, 8'h1F);
    apb(1'h0, 12'h100, 8'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    apb(1'h1, 12'h02D, 8'hAA);
    check("misaligned error", {31'h0, err}, 32'h1);
    apb(1'h0, 12'h02E, 8'h0);
    check("misaligned read error", {31'h0, err}, 32'h1);
    check("misaligned read data", rd, 32'h0);
    rreg(dfgm_pkg::IDX_MID_A, 8'h11);
  endtask
  task automatic test_fsk;
    wreg(dfgm_pkg::IDX_HIGH_A, 8'h01);
    wreg(dfgm_pkg::IDX_MID_A, 8'h23);
    wreg(dfgm_pkg::IDX_DEV, 8'hC1);
    wreg(dfgm_pkg::IDX_STEP_DIV, 8'h02);
    wreg(dfgm_pkg::IDX_SHAPE_CFG, 8'h08);
    wreg(dfgm_pkg::IDX_CTRL, 8'h01);
    send(8'hFF);
    check("one high", {11'h0, synth.frac}, {11'h0, CA + DEV});
    check("one high dir", {31'h0, synth.fsk_high}, 32'h1);
    wreg(dfgm_pkg::IDX_TX_CFG, 8'h0B);
    send(8'hFF);
    check("inverted one", {11'h0, synth.frac}, {11'h0, CA - DEV});
    send(8'h00);
    check("inverted zero", {11'h0, synth.frac}, {11'h0, CA + DEV});
  endtask
  task automatic test_gauss;
    wreg(dfgm_pkg::IDX_TX_CFG, 8'h03);
    wreg(dfgm_pkg::IDX_SHAPE_CFG, 8'h00);
    @(posedge pclk) clear <= 1'h1;
    @(posedge pclk) clear <= 1'h0;
    send(8'hFF);
    check("one shaped", {11'h0, synth.frac}, {11'h0, CA + DEV});
    check("shaping steps", {16'h0, changes}, 32'h10);
    check("step pacing", {16'h0, span}, 32'd45);
  endtask
  task automatic test_ask;
    int n;
    wreg(dfgm_pkg::IDX_HIGH_B, 8'h02);
    wreg(dfgm_pkg::IDX_MID_B, 8'h77);
    wreg(dfgm_pkg::IDX_TX_CFG, 8'h02);
    wreg(dfgm_pkg::IDX_CTRL, 8'h05);
    wreg(dfgm_pkg::IDX_TX_DATA, 8'hFF);
    n = 0;
    while (ask_level !== 1'h1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check("ask level", {31'h0, ask_level}, 32'h1);
    drain();
    check("ask centre", {11'h0, synth.frac}, {11'h0, CB});
    check("ask dir", {31'h0, synth.fsk_high}, 32'h0);
    check("ask idle", {31'h0, ask_level}, 32'h0);
    wreg(dfgm_pkg::IDX_CTRL, 8'h07);
    send(8'hFF);
    check("setup two", {11'h0, synth.frac}, {11'h0, CB + DEV});
  endtask
  task automatic test_fifo;
    wreg(dfgm_pkg::IDX_CTRL, 8'h00);
    repeat (dfgm_pkg::FIFO_DEPTH) wreg(dfgm_pkg::IDX_TX_DATA, 8'hA5);
    apb(1'h0, {2'h0, dfgm_pkg::IDX_STATUS, 2'h0}, 8'h0);
    check("status", rd, 32'h00000106);
    check("status error", {31'h0, err}, 32'h0);
    check("fifo full", {30'h0, rd[1:0]}, 32'h2);
    wreg(dfgm_pkg::IDX_CTRL, 8'h01);
    send(8'hA5);
    apb(1'h0, {2'h0, dfgm_pkg::IDX_STATUS, 2'h0}, 8'h0);
    check("fifo empty", {30'h0, rd[1:0]}, 32'h1);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, clear} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    test_regs();
    test_fsk();
    test_gauss();
    test_ask();
    test_fifo();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
